// [pfs_pkg.sv]
// Package for the port frame statistics block: widths, thresholds, event carriers.
// Assumes a single 200 MHz clock domain.
package pfs_pkg;
   localparam int CNT_W        = 32;
   localparam int OCT_W        = 48;
   localparam int LEN_W        = 16;
   localparam logic [LEN_W-1:0] LEN_MIN      = 16'h0040;  // 64 bytes
   localparam logic [LEN_W-1:0] LEN_MAX      = 16'h0600;  // 1536 bytes
   localparam logic [LEN_W-1:0] LEN_BIN1_TOP = 16'h007f;
   localparam logic [LEN_W-1:0] LEN_BIN2_TOP = 16'h00ff;
   localparam logic [LEN_W-1:0] LEN_BIN3_TOP = 16'h01ff;
   localparam logic [LEN_W-1:0] LEN_BIN4_TOP = 16'h03ff;
   localparam logic [LEN_W-1:0] LATE_COL_OCT = 16'h0040;  // 64th octet
   localparam int  NUM_ERR      = 8;
   localparam int  NUM_HIST     = 6;
   localparam longint CLK_HZ    = 200000000;
   localparam longint PER5_S    = 5;
   localparam longint PER15_S   = 15;
   localparam longint PER30_S   = 30;
   localparam longint PER60_S   = 60;
   localparam longint PER5_CYC  = PER5_S * CLK_HZ;
   localparam longint PER15_CYC = PER15_S * CLK_HZ;
   localparam longint PER30_CYC = PER30_S * CLK_HZ;
   localparam longint PER60_CYC = PER60_S * CLK_HZ;
   localparam int  TMR_W        = 34;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

   typedef enum logic [2:0] {
      PFS_INT_5S      = 3'b000,
      PFS_INT_15S     = 3'b001,
      PFS_INT_30S     = 3'b010,
      PFS_INT_60S     = 3'b011,
      PFS_INT_SUSPEND = 3'b100
   } pfs_interval_t;

   // One received frame, reported by the MAC at frame end
   typedef struct packed {
      logic             valid;
      logic [LEN_W-1:0] len;
      logic             crc_ok;
      logic             align_err;
      logic             mac_err;
      logic             dropped;
      logic             is_mcast;
      logic             is_bcast;
   } pfs_rx_evt_t;

   // One transmitted frame at frame end
   typedef struct packed {
      logic             valid;
      logic             good;
      logic [LEN_W-1:0] len;
      logic             is_mcast;
      logic             is_bcast;
   } pfs_tx_evt_t;

   // Collision seen during transmit, with the octet position
   typedef struct packed {
      logic             valid;
      logic [LEN_W-1:0] octet;
   } pfs_col_evt_t;

   typedef struct packed {
      logic [CNT_W-1:0] crc_err;
      logic [CNT_W-1:0] oversize;
      logic [CNT_W-1:0] fragment;
      logic [CNT_W-1:0] jabber;
      logic [CNT_W-1:0] late_col;
      logic [CNT_W-1:0] mac_rx_err;
      logic [CNT_W-1:0] dropped;
      logic [CNT_W-1:0] undersize;
      logic [CNT_W-1:0] total_err;
      logic [CNT_W-1:0] collisions;
   } pfs_err_snap_t;

   typedef struct packed {
      logic [CNT_W-1:0] hist64;
      logic [CNT_W-1:0] hist127;
      logic [CNT_W-1:0] hist255;
      logic [CNT_W-1:0] hist511;
      logic [CNT_W-1:0] hist1023;
      logic [CNT_W-1:0] hist1536;
      logic [CNT_W-1:0] rx_good;
      logic [CNT_W-1:0] tx_good;
      logic [CNT_W-1:0] rx_total;
      logic [OCT_W-1:0] tx_oct;
      logic [OCT_W-1:0] rx_good_oct;
      logic [OCT_W-1:0] rx_total_oct;
      logic [CNT_W-1:0] rx_ucast;
      logic [CNT_W-1:0] tx_ucast;
      logic [CNT_W-1:0] rx_mcast;
      logic [CNT_W-1:0] tx_mcast;
      logic [CNT_W-1:0] rx_bcast;
      logic [CNT_W-1:0] tx_bcast;
   } pfs_pkt_snap_t;
endpackage : pfs_pkg

// [pfs_counter.sv]
// Saturation-free event counter with a variable increment.
// Assumes the increment is presented for one cycle per event.
`timescale 1ns/1ps
`default_nettype none
module pfs_counter #(
   parameter int W = 32
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         inc_in,
   input  wire logic [W-1:0] step_in,
   output logic      [W-1:0] count_out
);
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_out <= '0;
      end else if (inc_in) begin
         count_out <= count_out + step_in;
      end
   end
endmodule : pfs_counter
`default_nettype wire

// [pfs_port_stats.sv]
// Per-port frame statistics: error, length, traffic and octet counters,
// plus periodic snapshots for management display.
// Assumes MAC event strobes are single-cycle and synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Count received frames failing the check sequence
// - Count frames with good check sequence longer than 1536 bytes
// - Count short frames with alignment or CRC fault
// - Count long frames with CRC or alignment fault
// - Count collisions at or after octet 64
// - Count frames flagged with MAC receive error
// - Count frames dropped by this port
// - Count short frames with good check sequence
// - Total errors is sum of eight counters
// - Count every collision on the port
// - Six-bin frame length histogram
// - Count good received frames, dropped included
// - Count good transmitted frames
// - Count all received frames
// - Sum octets of good transmitted frames
// - Sum octets of good received frames
// - Sum octets of all received frames
// - Count good unicast frames each direction
// - Count good multicast frames each direction
// - Count good broadcast frames each direction
// - Snapshot every 5/15/30/60 s or suspend
module pfs_port_stats #(
   parameter longint P5_CYC  = pfs_pkg::PER5_CYC,
   parameter longint P15_CYC = pfs_pkg::PER15_CYC,
   parameter longint P30_CYC = pfs_pkg::PER30_CYC,
   parameter longint P60_CYC = pfs_pkg::PER60_CYC
) (
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   input  wire pfs_pkg::pfs_rx_evt_t   rx_evt_in,
   input  wire pfs_pkg::pfs_tx_evt_t   tx_evt_in,
   input  wire pfs_pkg::pfs_col_evt_t  col_evt_in,
   input  wire pfs_pkg::pfs_interval_t interval_in,
   output var  pfs_pkg::pfs_err_snap_t err_snap_out,
   output var  pfs_pkg::pfs_pkt_snap_t pkt_snap_out,
   output logic                        snap_strobe_out
);
   import pfs_pkg::*;

   // Received-frame classification
   logic rx_v, rx_long, rx_short, rx_bad, rx_good;
   logic [NUM_ERR-1:0]  err_inc;
   logic [NUM_HIST-1:0] hist_inc;
   logic [CNT_W-1:0]    err_cnt [NUM_ERR];
   logic [CNT_W-1:0]    hist_cnt [NUM_HIST];
   logic [CNT_W-1:0]    collisions;

   assign rx_v     = rx_evt_in.valid;
   assign rx_long  = rx_evt_in.len > LEN_MAX;
   assign rx_short = rx_evt_in.len < LEN_MIN;
   assign rx_bad   = !rx_evt_in.crc_ok || rx_evt_in.align_err;
   // Good means clean CRC, framing and MAC status; drops still count as good
   assign rx_good  = rx_v && !rx_bad && !rx_evt_in.mac_err;

   always_comb begin
      err_inc[0] = rx_v && !rx_evt_in.crc_ok;
      err_inc[1] = rx_v && rx_evt_in.crc_ok && rx_long;
      err_inc[2] = rx_v && rx_short && rx_bad;
      err_inc[3] = rx_v && rx_long && rx_bad;
      err_inc[4] = col_evt_in.valid && (col_evt_in.octet >= LATE_COL_OCT);
      err_inc[5] = rx_v && rx_evt_in.mac_err;
      err_inc[6] = rx_v && rx_evt_in.dropped;
      err_inc[7] = rx_v && rx_evt_in.crc_ok && rx_short;
   end

   // Histogram takes every received frame in range, good or not
   always_comb begin
      hist_inc[0] = rx_v && (rx_evt_in.len == LEN_MIN);
      hist_inc[1] = rx_v && (rx_evt_in.len > LEN_MIN)
                    && (rx_evt_in.len <= LEN_BIN1_TOP);
      hist_inc[2] = rx_v && (rx_evt_in.len > LEN_BIN1_TOP)
                    && (rx_evt_in.len <= LEN_BIN2_TOP);
      hist_inc[3] = rx_v && (rx_evt_in.len > LEN_BIN2_TOP)
                    && (rx_evt_in.len <= LEN_BIN3_TOP);
      hist_inc[4] = rx_v && (rx_evt_in.len > LEN_BIN3_TOP)
                    && (rx_evt_in.len <= LEN_BIN4_TOP);
      hist_inc[5] = rx_v && (rx_evt_in.len > LEN_BIN4_TOP)
                    && (rx_evt_in.len <= LEN_MAX);
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_ERR; gi++) begin : g_err
         pfs_counter #(.W(CNT_W)) u_cnt (
            .clk_in    (clk_in),
            .rst_in    (rst_in),
            .inc_in    (err_inc[gi]),
            .step_in   (CNT_ONE),
            .count_out (err_cnt[gi])
         );
      end
      for (gi = 0; gi < NUM_HIST; gi++) begin : g_hist
         pfs_counter #(.W(CNT_W)) u_cnt (
            .clk_in    (clk_in),
            .rst_in    (rst_in),
            .inc_in    (hist_inc[gi]),
            .step_in   (CNT_ONE),
            .count_out (hist_cnt[gi])
         );
      end
   endgenerate

   pfs_counter #(.W(CNT_W)) u_col (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .inc_in    (col_evt_in.valid),
      .step_in   (CNT_ONE),
      .count_out (collisions)
   );

   // Traffic counters, one process per group
   logic [CNT_W-1:0] rx_good_cnt, tx_good_cnt, rx_total_cnt;
   logic [OCT_W-1:0] tx_oct, rx_good_oct, rx_total_oct;
   logic [CNT_W-1:0] rx_uc, tx_uc, rx_mc, tx_mc, rx_bc, tx_bc;
   logic [OCT_W-1:0] rx_len_w, tx_len_w;
   logic tx_ok, rx_uni, tx_uni;

   assign rx_len_w = {{(OCT_W-LEN_W){1'b0}}, rx_evt_in.len};
   assign tx_len_w = {{(OCT_W-LEN_W){1'b0}}, tx_evt_in.len};
   assign tx_ok    = tx_evt_in.valid && tx_evt_in.good;
   assign rx_uni   = !rx_evt_in.is_mcast && !rx_evt_in.is_bcast;
   assign tx_uni   = !tx_evt_in.is_mcast && !tx_evt_in.is_bcast;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_good_cnt  <= '0;
         rx_total_cnt <= '0;
         rx_good_oct  <= '0;
         rx_total_oct <= '0;
      end else begin
         if (rx_good) begin
            rx_good_cnt <= rx_good_cnt + CNT_ONE;
            rx_good_oct <= rx_good_oct + rx_len_w;
         end
         if (rx_v) begin
            rx_total_cnt <= rx_total_cnt + CNT_ONE;
            rx_total_oct <= rx_total_oct + rx_len_w;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_good_cnt <= '0;
         tx_oct      <= '0;
      end else if (tx_ok) begin
         tx_good_cnt <= tx_good_cnt + CNT_ONE;
         tx_oct      <= tx_oct + tx_len_w;
      end
   end

   // Broadcast wins over multicast when both flags are set
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_uc <= '0;
         rx_mc <= '0;
         rx_bc <= '0;
      end else if (rx_good) begin
         if (rx_evt_in.is_bcast) begin
            rx_bc <= rx_bc + CNT_ONE;
         end else if (rx_evt_in.is_mcast) begin
            rx_mc <= rx_mc + CNT_ONE;
         end else if (rx_uni) begin
            rx_uc <= rx_uc + CNT_ONE;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_uc <= '0;
         tx_mc <= '0;
         tx_bc <= '0;
      end else if (tx_ok) begin
         if (tx_evt_in.is_bcast) begin
            tx_bc <= tx_bc + CNT_ONE;
         end else if (tx_evt_in.is_mcast) begin
            tx_mc <= tx_mc + CNT_ONE;
         end else if (tx_uni) begin
            tx_uc <= tx_uc + CNT_ONE;
         end
      end
   end

   // Total errors, wraps modulo the counter width like the parts
   logic [CNT_W-1:0] total_err;
   always_comb begin
      total_err = '0;
      for (int i = 0; i < NUM_ERR; i++) begin
         total_err = total_err + err_cnt[i];
      end
   end

   // Sample timer; a new interval restarts the period
   logic [TMR_W-1:0] tmr;
   logic [TMR_W-1:0] period;
   logic             suspend;
   pfs_interval_t    interval_q;
   logic             tick;

   always_comb begin
      suspend = 1'b0;
      case (interval_in)
         PFS_INT_5S:  period = TMR_W'(P5_CYC - 1);
         PFS_INT_15S: period = TMR_W'(P15_CYC - 1);
         PFS_INT_30S: period = TMR_W'(P30_CYC - 1);
         PFS_INT_60S: period = TMR_W'(P60_CYC - 1);
         default: begin
            period  = '0;
            suspend = 1'b1;
         end
      endcase
   end

   assign tick = !suspend && (tmr >= period);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tmr        <= '0;
         interval_q <= PFS_INT_SUSPEND;
      end else begin
         interval_q <= interval_in;
         if (suspend || (interval_q != interval_in) || tick) begin
            tmr <= '0;
         end else begin
            tmr <= tmr + TMR_W'(1);
         end
      end
   end

   // Snapshots hold between samples so the display stays consistent
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         err_snap_out    <= '0;
         pkt_snap_out    <= '0;
         snap_strobe_out <= 1'b0;
      end else begin
         snap_strobe_out <= tick;
         if (tick) begin
            err_snap_out.crc_err    <= err_cnt[0];
            err_snap_out.oversize   <= err_cnt[1];
            err_snap_out.fragment   <= err_cnt[2];
            err_snap_out.jabber     <= err_cnt[3];
            err_snap_out.late_col   <= err_cnt[4];
            err_snap_out.mac_rx_err <= err_cnt[5];
            err_snap_out.dropped    <= err_cnt[6];
            err_snap_out.undersize  <= err_cnt[7];
            err_snap_out.total_err  <= total_err;
            err_snap_out.collisions <= collisions;
            pkt_snap_out.hist64       <= hist_cnt[0];
            pkt_snap_out.hist127      <= hist_cnt[1];
            pkt_snap_out.hist255      <= hist_cnt[2];
            pkt_snap_out.hist511      <= hist_cnt[3];
            pkt_snap_out.hist1023     <= hist_cnt[4];
            pkt_snap_out.hist1536     <= hist_cnt[5];
            pkt_snap_out.rx_good      <= rx_good_cnt;
            pkt_snap_out.tx_good      <= tx_good_cnt;
            pkt_snap_out.rx_total     <= rx_total_cnt;
            pkt_snap_out.tx_oct       <= tx_oct;
            pkt_snap_out.rx_good_oct  <= rx_good_oct;
            pkt_snap_out.rx_total_oct <= rx_total_oct;
            pkt_snap_out.rx_ucast     <= rx_uc;
            pkt_snap_out.tx_ucast     <= tx_uc;
            pkt_snap_out.rx_mcast     <= rx_mc;
            pkt_snap_out.tx_mcast     <= tx_mc;
            pkt_snap_out.rx_bcast     <= rx_bc;
            pkt_snap_out.tx_bcast     <= tx_bc;
         end
      end
   end

   // Checks
   a_crc_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && !rx_evt_in.crc_ok) |=> (err_cnt[0] == $past(err_cnt[0]) + CNT_ONE))
      else $error("crc error count did not step");
   a_oversize_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_evt_in.crc_ok && rx_evt_in.len == LEN_MAX + 16'h0001)
      |=> (err_cnt[1] != $past(err_cnt[1])))
      else $error("oversize frame not counted");
   a_max_not_oversize: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_evt_in.len <= LEN_MAX) |=> (err_cnt[1] == $past(err_cnt[1])))
      else $error("legal length counted as oversize");
   a_fragment_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_short && rx_evt_in.align_err) |=> (err_cnt[2] == $past(err_cnt[2]) + CNT_ONE))
      else $error("fragment not counted");
   a_jabber_count: assert property (@(posedge clk_in) disable iff (rst_in)
      !(rx_v && rx_long && rx_bad) |=> $stable(err_cnt[3]))
      else $error("jabber counted without cause");
   a_late_col_edge: assert property (@(posedge clk_in) disable iff (rst_in)
      (col_evt_in.valid && col_evt_in.octet == LATE_COL_OCT - 16'h0001)
      |=> $stable(err_cnt[4]) && (collisions == $past(collisions) + CNT_ONE))
      else $error("early collision misclassified");
   a_undersize_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_evt_in.crc_ok && rx_evt_in.len == LEN_MIN - 16'h0001)
      |=> (err_cnt[7] == $past(err_cnt[7]) + CNT_ONE))
      else $error("undersize not counted");
   a_hist_exact64: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_evt_in.len == LEN_MIN) |=> $stable(hist_cnt[1])
      && (hist_cnt[0] == $past(hist_cnt[0]) + CNT_ONE))
      else $error("64-byte frame in wrong bin");
   a_rx_octets: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_v |=> (rx_total_oct == $past(rx_total_oct) + $past(rx_len_w)))
      else $error("received octets not accumulated");
   sequence s_sample;
      tick ##1 snap_strobe_out;
   endsequence
   a_snap_strobe: assert property (@(posedge clk_in) disable iff (rst_in)
      tick |-> s_sample)
      else $error("sample strobe missing");
   a_suspend_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      (interval_in == PFS_INT_SUSPEND) [*2] |-> !snap_strobe_out)
      else $error("sample taken while suspended");
   a_rx_good_count: assert property (@(posedge clk_in) disable iff (rst_in)
      rx_good |=> (rx_good_cnt == $past(rx_good_cnt) + CNT_ONE)
      && (rx_good_oct == $past(rx_good_oct) + $past(rx_len_w)))
      else $error("good receive count or octets did not step");
   a_mac_err_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_evt_in.mac_err) |=> (err_cnt[5] == $past(err_cnt[5]) + CNT_ONE))
      else $error("receive error count did not step");
   a_drop_count: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_v && rx_evt_in.dropped) |=> (err_cnt[6] == $past(err_cnt[6]) + CNT_ONE))
      else $error("dropped count did not step");
   a_bcast_first: assert property (@(posedge clk_in) disable iff (rst_in)
      (rx_good && rx_evt_in.is_bcast) |=> ($stable(rx_mc) && $stable(rx_uc)
      && (rx_bc == $past(rx_bc) + CNT_ONE)))
      else $error("broadcast frame in wrong cast counter");
   a_tx_good_count: assert property (@(posedge clk_in) disable iff (rst_in)
      tx_ok |=> (tx_good_cnt == $past(tx_good_cnt) + CNT_ONE)
      && (tx_oct == $past(tx_oct) + $past(tx_len_w)))
      else $error("good transmit count or octets did not step");
   a_col_count: assert property (@(posedge clk_in) disable iff (rst_in)
      col_evt_in.valid |=> (collisions == $past(collisions) + CNT_ONE))
      else $error("collision not counted");
   a_total_sum: assert property (@(posedge clk_in) disable iff (rst_in)
      snap_strobe_out |-> (err_snap_out.total_err == err_snap_out.crc_err
      + err_snap_out.oversize + err_snap_out.fragment + err_snap_out.jabber
      + err_snap_out.late_col + err_snap_out.mac_rx_err + err_snap_out.dropped
      + err_snap_out.undersize))
      else $error("total error figure is not the sum");
endmodule : pfs_port_stats
`default_nettype wire

// [pfs_station_model.sv]
// Behavioural remote station: emits frame-end and collision events.
// Assumes callers step it once per falling edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module pfs_station_model (
   input  wire logic                  clk_in,
   output var  pfs_pkg::pfs_rx_evt_t  rx_evt_out,
   output var  pfs_pkg::pfs_tx_evt_t  tx_evt_out,
   output var  pfs_pkg::pfs_col_evt_t col_evt_out
);
   import pfs_pkg::*;

   initial begin
      rx_evt_out = '0;
      tx_evt_out = '0;
      col_evt_out = '0;
   end

   // One kind of event stands at a time, until the next call; back-to-back frames
   // take one edge each, and a left-over pulse of another kind is never counted twice
   task automatic send_rx(input logic [LEN_W-1:0] len, input logic [5:0] fl);
      @(negedge clk_in);
      rx_evt_out = {1'b1, len, fl};
      tx_evt_out.valid = 1'b0;
      col_evt_out.valid = 1'b0;
   endtask : send_rx

   task automatic send_tx(input logic [LEN_W-1:0] len, input logic [2:0] fl);
      @(negedge clk_in);
      tx_evt_out = {1'b1, fl[2], len, fl[1:0]};
      rx_evt_out.valid = 1'b0;
      col_evt_out.valid = 1'b0;
   endtask : send_tx

   task automatic send_col(input logic [LEN_W-1:0] octet);
      @(negedge clk_in);
      col_evt_out = {1'b1, octet};
      rx_evt_out.valid = 1'b0;
      tx_evt_out.valid = 1'b0;
   endtask : send_col

   // Idle fields flip so a design reading them without valid is caught
   task automatic quiet;
      @(negedge clk_in);
      rx_evt_out = {1'b0, ~rx_evt_out[21:0]};
      tx_evt_out = {1'b0, ~tx_evt_out[18:0]};
      col_evt_out = {1'b0, ~col_evt_out[15:0]};
   endtask : quiet
endmodule : pfs_station_model
`default_nettype wire

// [tb_top.sv]
// Testbench for the port statistics block: frame, collision and snapshot scenarios.
// Assumes shortened snapshot periods and the station model driving all events.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pfs_pkg::*;
   localparam logic [31:0] PER [4] = '{32'h14, 32'h28, 32'h3c, 32'h50};
   logic          clk_in;
   logic          rst_in;
   pfs_interval_t interval_in;
   pfs_rx_evt_t   rx_evt;
   pfs_tx_evt_t   tx_evt;
   pfs_col_evt_t  col_evt;
   pfs_err_snap_t err_snap;
   pfs_pkt_snap_t pkt_snap;
   logic          snap_strobe;
   pfs_err_snap_t e;
   pfs_pkt_snap_t p;
   int            failures;
   int            check_count;

   pfs_port_stats #(.P5_CYC(longint'(PER[0])), .P15_CYC(longint'(PER[1])),
      .P30_CYC(longint'(PER[2])), .P60_CYC(longint'(PER[3]))) pfs_port_stats_inst (
      .clk_in(clk_in), .rst_in(rst_in), .rx_evt_in(rx_evt), .tx_evt_in(tx_evt),
      .col_evt_in(col_evt), .interval_in(interval_in), .err_snap_out(err_snap),
      .pkt_snap_out(pkt_snap), .snap_strobe_out(snap_strobe));
   pfs_station_model pfs_station_model_inst (.clk_in(clk_in), .rx_evt_out(rx_evt),
      .tx_evt_out(tx_evt), .col_evt_out(col_evt));

   initial clk_in = 1'b0;
   always #2.5 clk_in = ~clk_in;

   function automatic logic [31:0] one_if(input logic x);
      return {31'h0, x};
   endfunction : one_if

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic cmp_err(input pfs_err_snap_t got, input pfs_err_snap_t exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t error snapshot %h expected %h", $time, got, exp);
      end
   endtask : cmp_err

   task automatic cmp_pkt(input pfs_pkt_snap_t got, input pfs_pkt_snap_t exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t traffic snapshot %h expected %h", $time, got, exp);
      end
   endtask : cmp_pkt

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   // Bounded wait; n is the number of falling edges until the strobe
   task automatic wait_strobe(output logic [31:0] n);
      n = 32'h0;
      repeat (200) begin
         @(negedge clk_in);
         n++;
         if (snap_strobe === 1'b1) return;
      end
      failures++;
      $display("BAD %0t no snapshot strobe", $time);
      final_report();
   endtask : wait_strobe

   task automatic wait_snap;
      logic [31:0] n;
      e.total_err = e.crc_err + e.oversize + e.fragment + e.jabber + e.late_col
                    + e.mac_rx_err + e.dropped + e.undersize;
      wait_strobe(n);
   endtask : wait_snap

   // Flags: crc_ok, align_err, mac_err, dropped, is_mcast, is_bcast
   task automatic rx(input logic [15:0] len, input logic [5:0] fl);
      pfs_station_model_inst.send_rx(len, fl);
      e.crc_err += one_if(~fl[5]);
      e.oversize += one_if(fl[5] && len > LEN_MAX);
      e.fragment += one_if(len < LEN_MIN && (~fl[5] || fl[4]));
      e.jabber += one_if(len > LEN_MAX && (~fl[5] || fl[4]));
      e.mac_rx_err += one_if(fl[3]);
      e.dropped += one_if(fl[2]);
      e.undersize += one_if(fl[5] && len < LEN_MIN);
      p.rx_total += 32'h1;
      p.rx_total_oct += {32'h0, len};
      p.hist64 += one_if(len == LEN_MIN);
      p.hist127 += one_if(len > LEN_MIN && len <= LEN_BIN1_TOP);
      p.hist255 += one_if(len > LEN_BIN1_TOP && len <= LEN_BIN2_TOP);
      p.hist511 += one_if(len > LEN_BIN2_TOP && len <= LEN_BIN3_TOP);
      p.hist1023 += one_if(len > LEN_BIN3_TOP && len <= LEN_BIN4_TOP);
      p.hist1536 += one_if(len > LEN_BIN4_TOP && len <= LEN_MAX);
      if (fl[5] && !fl[4] && !fl[3]) begin
         p.rx_good += 32'h1;
         p.rx_good_oct += {32'h0, len};
         if (fl[0]) p.rx_bcast += 32'h1;
         else if (fl[1]) p.rx_mcast += 32'h1;
         else p.rx_ucast += 32'h1;
      end
   endtask : rx

   // Flags: good, is_mcast, is_bcast
   task automatic tx(input logic [15:0] len, input logic [2:0] fl);
      pfs_station_model_inst.send_tx(len, fl);
      if (fl[2]) begin
         p.tx_good += 32'h1;
         p.tx_oct += {32'h0, len};
         if (fl[0]) p.tx_bcast += 32'h1;
         else if (fl[1]) p.tx_mcast += 32'h1;
         else p.tx_ucast += 32'h1;
      end
   endtask : tx

   task automatic col(input logic [15:0] octet);
      pfs_station_model_inst.send_col(octet);
      e.collisions += 32'h1;
      e.late_col += one_if(octet >= LATE_COL_OCT);
   endtask : col

   task automatic t_reset;
      @(negedge clk_in);
      cmp_err(err_snap, e);
      cmp_pkt(pkt_snap, p);
      cmp_val(one_if(snap_strobe), 32'h0);
   endtask : t_reset

   // Boundary lengths 63/64/1536/1537 with CRC and alignment faults, plus drop, MAC error and cast flags, back to back
   task automatic t_rx;
      logic [15:0] ln [17] = '{16'h40, 16'h3f, 16'h3f, 16'h3f, 16'h601, 16'h601, 16'h601,
         16'h41, 16'h7f, 16'h80, 16'hff, 16'h100, 16'h1ff, 16'h200, 16'h3ff, 16'h400, 16'h600};
      logic [5:0]  fl [17] = '{6'h20, 6'h20, 6'h00, 6'h30, 6'h20, 6'h00, 6'h30,
         6'h22, 6'h21, 6'h23, 6'h24, 6'h28, 6'h20, 6'h10, 6'h20, 6'h22, 6'h21};
      for (int i = 0; i < 17; i++) rx(ln[i], fl[i]);
      pfs_station_model_inst.quiet();
      wait_snap();
      cmp_err(err_snap, e);
      cmp_pkt(pkt_snap, p);
   endtask : t_rx

   task automatic t_tx;
      tx(16'h40, 3'h4);
      tx(16'h600, 3'h6);
      tx(16'h64, 3'h5);
      tx(16'hc8, 3'h0);
      tx(16'h3f, 3'h7);
      col(16'h0);
      col(16'h3f);
      col(16'h40);
      col(16'h5ff);
      pfs_station_model_inst.quiet();
      wait_snap();
      cmp_err(err_snap, e);
      cmp_pkt(pkt_snap, p);
   endtask : t_tx

   task automatic t_periods;
      logic [31:0] n;
      int          hits;
      for (int i = 0; i < 4; i++) begin
         interval_in = pfs_interval_t'(i);
         wait_strobe(n);
         wait_strobe(n);
         cmp_val(n, PER[i]);
      end
      interval_in = PFS_INT_SUSPEND;
      hits = 0;
      repeat (200) begin
         @(negedge clk_in);
         hits += int'(snap_strobe === 1'b1);
      end
      cmp_val(32'(hits), 32'h0);
      interval_in = PFS_INT_5S;
   endtask : t_periods

   // Counters must clear, not just the snapshot copies
   task automatic t_mid_reset;
      rx(16'h100, 6'h20);
      pfs_station_model_inst.quiet();
      @(negedge clk_in);
      rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      e = '0;
      p = '0;
      cmp_err(err_snap, e);
      wait_snap();
      cmp_err(err_snap, e);
      cmp_pkt(pkt_snap, p);
   endtask : t_mid_reset

   initial begin
      rst_in = 1'b1;
      interval_in = PFS_INT_5S;
      e = '0;
      p = '0;
      failures = 0;
      check_count = 0;
      repeat (10) @(negedge clk_in);
      rst_in = 1'b0;
      t_reset();
      t_rx();
      t_tx();
      t_periods();
      t_mid_reset();
      final_report();
   end
endmodule : tb_top
`default_nettype wire
